//--- design/rmc_pkg.sv
// Purpose: Constants for the radio link-layer settings and statistics bank.
// Assumes: One 100 MHz clock; host reaches values by command select codes.
package rmc_pkg;
  // Command select codes for host accesses
  localparam logic [3:0] SEL_AIR_RATE = 4'h0;
  localparam logic [3:0] SEL_TX_POWER = 4'h1;
  localparam logic [3:0] SEL_RETRY = 4'h2;
  localparam logic [3:0] SEL_TX_BYTES = 4'h3;
  localparam logic [3:0] SEL_RSSI = 4'h4;
  localparam logic [3:0] SEL_RX_ERR = 4'h5;
  localparam logic [3:0] SEL_GOOD = 4'h6;
  localparam logic [3:0] SEL_ACK_FAIL = 4'h7;
  localparam logic [3:0] SEL_TX_FAIL = 4'h8;
  localparam logic [3:0] SEL_UCAST_ATT = 4'h9;
  localparam logic [3:0] SEL_UCAST_TO = 4'hA;
  localparam logic [3:0] SEL_BCAST_TO = 4'hB;
  localparam logic [3:0] SEL_ROLE = 4'hC;
  // Reset values and ranges
  localparam logic [1:0] RATE_RST = 2'h2;
  localparam logic [1:0] RATE_MAX = 2'h2;
  localparam logic [1:0] POWER_RST = 2'h2;
  localparam logic [1:0] POWER_MAX = 2'h2;
  localparam logic [3:0] RETRY_RST = 4'hA;
  localparam logic [2:0] ROLE_RST = 3'h0;
  localparam logic [2:0] ROLE_MAX = 3'h6;
  localparam logic [15:0] UCAST_TO_RST = 16'h0267;
  localparam logic [15:0] BCAST_TO_RST = 16'h0000;
  localparam logic [7:0] RSSI_MIN = 8'h28;
  localparam logic [7:0] RSSI_MAX = 8'h6E;
  // Roles
  localparam logic [2:0] ROLE_ROUTER = 3'h0;
  localparam logic [2:0] ROLE_IND_COORD = 3'h1;
  localparam logic [2:0] ROLE_NR_NODE = 3'h2;
  localparam logic [2:0] ROLE_NR_COORD = 3'h3;
  localparam logic [2:0] ROLE_IND_POLLER = 3'h4;
  localparam logic [2:0] ROLE_UNUSED = 3'h5;
  localparam logic [2:0] ROLE_NR_POLLER = 3'h6;
  // Regions
  localparam logic [1:0] REG_AUSTRALIA = 2'h0;
  localparam logic [1:0] REG_BRAZIL = 2'h1;
  localparam logic [1:0] REG_NEW_ZEALAND = 2'h2;
  localparam logic [1:0] REG_FRANCE = 2'h3;
  // Timing: millisecond tick at the system clock rate
  localparam int CLK_MHZ = 100;
  localparam int TICK_MS = 1;
  localparam int TICK_CYCLES = TICK_MS * 1000 * CLK_MHZ;
  localparam int POLL_MS = 100;

  // Hopping pattern count for region and high-rate flag
  function automatic logic [3:0] rmc_patterns(input logic [1:0] region,
                                              input logic hi);
    unique case (region)
      REG_BRAZIL: rmc_patterns = 4'hA;
      REG_FRANCE: rmc_patterns = 4'h8;
      default: rmc_patterns = hi ? 4'h8 : 4'hA;
    endcase
  endfunction : rmc_patterns

  // Hopping channel count for region and high-rate flag
  function automatic logic [5:0] rmc_channels(input logic [1:0] region,
                                              input logic hi);
    unique case (region)
      REG_AUSTRALIA: rmc_channels = hi ? 6'h18 : 6'h31;
      REG_BRAZIL: rmc_channels = hi ? 6'h23 : 6'h32;
      REG_NEW_ZEALAND: rmc_channels = hi ? 6'h0B : 6'h29;
      default: rmc_channels = 6'h0C;
    endcase
  endfunction : rmc_channels
endpackage : rmc_pkg

//--- design/rmc_bank.sv
// Purpose: Link-layer settings and saturating statistics bank.
// Assumes: Event inputs come from link logic on clk_sys, pulses one cycle.
// Notes: Command accesses answer one cycle later with rsp_valid.
`timescale 1ns/1ps
`default_nettype none
module rmc_bank import rmc_pkg::*; #(
  parameter int TICK_CYC = TICK_CYCLES, // Cycles per millisecond tick
  parameter int POLL_PERIOD_MS = POLL_MS // Poll interval in ticks
) (
  input wire logic clk_sys,
  input wire logic arst_n,
  // Host command port
  input wire logic cmd_valid,
  input wire logic cmd_write,
  input wire logic [3:0] cmd_sel,
  input wire logic [31:0] cmd_wdata,
  output logic rsp_valid,
  output logic rsp_error,
  output logic [31:0] rsp_rdata,
  // Link events
  input wire logic [7:0] evt_tx_bytes,
  input wire logic evt_rx_pkt,
  input wire logic [7:0] evt_rx_rssi,
  input wire logic evt_rx_bad,
  input wire logic evt_rx_good,
  input wire logic evt_rx_is_ack,
  input wire logic evt_ack_timeout,
  input wire logic evt_tx_fail,
  input wire logic evt_ucast_sent,
  input wire logic [15:0] ucast_timeout_in,
  input wire logic [15:0] bcast_timeout_in,
  input wire logic [1:0] region_sel,
  // Settings and role controls
  output logic [1:0] air_data_rate,
  output logic [1:0] transmit_power_level,
  output logic [3:0] unicast_retry_limit,
  output logic ack_request,
  output logic sync_sleep_allowed,
  output logic [3:0] hopping_pattern_count,
  output logic [5:0] hopping_channel_count,
  output logic repeat_broadcasts,
  output logic hold_indirect,
  output logic poll_pulse
);
  // All state of the bank
  typedef struct packed {
    logic [1:0] rate;
    logic [1:0] power;
    logic [3:0] retry;
    logic [2:0] role;
    logic [31:0] txb;
    logic [7:0] rssi;
    logic [15:0] rxerr;
    logic [15:0] good;
    logic [15:0] ackf;
    logic [15:0] txfail;
    logic [15:0] uatt;
    logic [15:0] uto;
    logic [15:0] bto;
    logic recalc;
    logic rsp_v;
    logic rsp_e;
    logic [31:0] rsp_d;
    logic sync_ok;
    logic ack_req;
    logic [3:0] pat;
    logic [5:0] chan;
    logic route;
    logic indirect;
    logic [31:0] tick_cnt;
    logic [31:0] poll_cnt;
    logic poll;
  } rmc_state_t;

  rmc_state_t s_ff; // Registered state
  rmc_state_t nxt_s; // Next state

  // Saturating add for the byte counter
  function automatic logic [31:0] rmc_sat32(input logic [31:0] v,
                                            input logic [7:0] n);
    logic [32:0] sum;
    sum = {1'b0, v} + {25'h0000000, n};
    rmc_sat32 = sum[32] ? 32'hFFFFFFFF : sum[31:0];
  endfunction : rmc_sat32

  // Saturating increment for the 16-bit counters
  function automatic logic [15:0] rmc_inc16(input logic [15:0] v,
                                            input logic ev);
    rmc_inc16 = (ev && v != 16'hFFFF) ? v + 16'h0001 : v;
  endfunction : rmc_inc16

  // Routing roles
  function automatic logic rmc_routes(input logic [2:0] r);
    rmc_routes = (r == ROLE_ROUTER) || (r == ROLE_IND_COORD) ||
                 (r == ROLE_IND_POLLER);
  endfunction : rmc_routes

  logic wr; // Accepted host write strobe
  logic rd; // Host read strobe
  assign wr = cmd_valid && cmd_write;
  assign rd = cmd_valid && !cmd_write;

  // Next-state logic
  always_comb begin
    logic bad;
    logic [31:0] rdata;
    logic poller;
    bad = 1'b0;
    rdata = 32'h00000000;
    poller = 1'b0;
    nxt_s = s_ff;
    nxt_s.poll = 1'b0;
    // Statistics counters; preset value is counted from in the same cycle
    nxt_s.txb = rmc_sat32(s_ff.txb, evt_tx_bytes);
    if (evt_rx_pkt) begin
      nxt_s.rssi = evt_rx_rssi;
    end
    // Sleep mode is not an input here, so it cannot disturb this count
    nxt_s.rxerr = rmc_inc16(s_ff.rxerr, evt_rx_bad);
    nxt_s.good = rmc_inc16(s_ff.good, evt_rx_good && !evt_rx_is_ack);
    nxt_s.ackf = rmc_inc16(s_ff.ackf, evt_ack_timeout);
    nxt_s.txfail = rmc_inc16(s_ff.txfail, evt_tx_fail);
    nxt_s.uatt = rmc_inc16(s_ff.uatt,
                           evt_ucast_sent && s_ff.retry != 4'h0);
    // Timeouts reload one cycle after a rate, retry or role setting changes
    if (s_ff.recalc) begin
      nxt_s.uto = ucast_timeout_in;
      nxt_s.bto = bcast_timeout_in;
    end
    nxt_s.recalc = 1'b0;
    // Read mux
    unique case (cmd_sel)
      SEL_AIR_RATE: rdata = {30'h00000000, s_ff.rate};
      SEL_TX_POWER: rdata = {30'h00000000, s_ff.power};
      SEL_RETRY: rdata = {28'h0000000, s_ff.retry};
      SEL_TX_BYTES: rdata = s_ff.txb;
      SEL_RSSI: rdata = {24'h000000, s_ff.rssi};
      SEL_RX_ERR: rdata = {16'h0000, s_ff.rxerr};
      SEL_GOOD: rdata = {16'h0000, s_ff.good};
      SEL_ACK_FAIL: rdata = {16'h0000, s_ff.ackf};
      SEL_TX_FAIL: rdata = {16'h0000, s_ff.txfail};
      SEL_UCAST_ATT: rdata = {16'h0000, s_ff.uatt};
      SEL_UCAST_TO: rdata = {16'h0000, s_ff.uto};
      SEL_BCAST_TO: rdata = {16'h0000, s_ff.bto};
      SEL_ROLE: rdata = {29'h00000000, s_ff.role};
      default: bad = 1'b1; // Unmapped select
    endcase
    // Host writes; out-of-range values keep the old setting
    if (wr) begin
      unique case (cmd_sel)
        SEL_AIR_RATE: begin
          if (cmd_wdata > {30'h00000000, RATE_MAX}) begin
            bad = 1'b1;
          end else begin
            nxt_s.rate = cmd_wdata[1:0];
            nxt_s.recalc = 1'b1;
          end
        end
        SEL_TX_POWER: begin
          if (cmd_wdata > {30'h00000000, POWER_MAX}) begin
            bad = 1'b1;
          end else begin
            nxt_s.power = cmd_wdata[1:0];
          end
        end
        SEL_RETRY: begin
          if (cmd_wdata[31:4] != 28'h0000000) begin
            bad = 1'b1;
          end else begin
            nxt_s.retry = cmd_wdata[3:0];
            nxt_s.recalc = 1'b1;
          end
        end
        SEL_TX_BYTES: nxt_s.txb = rmc_sat32(cmd_wdata, evt_tx_bytes);
        SEL_RX_ERR, SEL_GOOD, SEL_ACK_FAIL: begin
          if (cmd_wdata[31:16] != 16'h0000) begin
            bad = 1'b1;
          end else if (cmd_sel == SEL_RX_ERR) begin
            nxt_s.rxerr = rmc_inc16(cmd_wdata[15:0], evt_rx_bad);
          end else if (cmd_sel == SEL_GOOD) begin
            nxt_s.good = rmc_inc16(cmd_wdata[15:0],
                                   evt_rx_good && !evt_rx_is_ack);
          end else begin
            nxt_s.ackf = rmc_inc16(cmd_wdata[15:0], evt_ack_timeout);
          end
        end
        SEL_ROLE: begin
          if (cmd_wdata > {29'h00000000, ROLE_MAX}) begin
            bad = 1'b1;
          end else begin
            nxt_s.role = cmd_wdata[2:0];
            nxt_s.recalc = 1'b1;
          end
        end
        default: bad = 1'b1; // Read-only or unmapped
      endcase
    end
    // Answer one cycle after the command
    nxt_s.rsp_v = cmd_valid;
    nxt_s.rsp_e = cmd_valid && bad;
    nxt_s.rsp_d = (rd && !bad) ? rdata : 32'h00000000;
    // Derived controls, registered so outputs come from flops
    nxt_s.sync_ok = (nxt_s.rate != 2'h0);
    nxt_s.ack_req = (nxt_s.retry != 4'h0);
    nxt_s.pat = rmc_patterns(region_sel, nxt_s.rate == 2'h2);
    nxt_s.chan = rmc_channels(region_sel, nxt_s.rate == 2'h2);
    nxt_s.route = rmc_routes(nxt_s.role);
    nxt_s.indirect = (nxt_s.role == ROLE_IND_COORD);
    // Poll timer: millisecond divider, then interval counter
    poller = (s_ff.role == ROLE_IND_POLLER) || (s_ff.role == ROLE_NR_POLLER);
    if (!poller) begin
      nxt_s.tick_cnt = 32'h00000000;
      nxt_s.poll_cnt = 32'h00000000;
    end else if (s_ff.tick_cnt == 32'(TICK_CYC - 1)) begin
      nxt_s.tick_cnt = 32'h00000000;
      if (s_ff.poll_cnt == 32'(POLL_PERIOD_MS - 1)) begin
        nxt_s.poll_cnt = 32'h00000000;
        nxt_s.poll = 1'b1;
      end else begin
        nxt_s.poll_cnt = s_ff.poll_cnt + 32'h00000001;
      end
    end else begin
      nxt_s.tick_cnt = s_ff.tick_cnt + 32'h00000001;
    end
  end

  // State register; reset clears all volatile statistics
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      s_ff <= '0;
      s_ff.rate <= RATE_RST;
      s_ff.power <= POWER_RST;
      s_ff.retry <= RETRY_RST;
      s_ff.role <= ROLE_RST;
      s_ff.uto <= UCAST_TO_RST;
      s_ff.bto <= BCAST_TO_RST;
      s_ff.sync_ok <= 1'b1;
      s_ff.ack_req <= 1'b1;
      s_ff.pat <= 4'h8;
      s_ff.chan <= 6'h18;
      s_ff.route <= 1'b1;
    end else begin
      s_ff <= nxt_s;
    end
  end

  // Outputs straight from state flops
  assign rsp_valid = s_ff.rsp_v;
  assign rsp_error = s_ff.rsp_e;
  assign rsp_rdata = s_ff.rsp_d;
  assign air_data_rate = s_ff.rate;
  assign transmit_power_level = s_ff.power;
  assign unicast_retry_limit = s_ff.retry;
  assign ack_request = s_ff.ack_req;
  assign sync_sleep_allowed = s_ff.sync_ok;
  assign hopping_pattern_count = s_ff.pat;
  assign hopping_channel_count = s_ff.chan;
  assign repeat_broadcasts = s_ff.route;
  assign hold_indirect = s_ff.indirect;
  assign poll_pulse = s_ff.poll;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!arst_n);

  property p_rate_range;
    s_ff.rate <= RATE_MAX;
  endproperty
  a_rate_range: assert property (p_rate_range)
    else $error("data rate out of range");

  property p_sync_sleep;
    ##1 (sync_sleep_allowed == (air_data_rate != 2'h0));
  endproperty
  a_sync_sleep: assert property (p_sync_sleep)
    else $error("sync sleep flag disagrees with data rate");

  property p_reject;
    (wr && cmd_sel == SEL_AIR_RATE && cmd_wdata > 32'h00000002)
      |=> (rsp_error && $stable(air_data_rate));
  endproperty
  a_reject: assert property (p_reject)
    else $error("bad data rate write was accepted");

  property p_rxerr_sat;
    (s_ff.rxerr == 16'hFFFF && !wr) |=> (s_ff.rxerr == 16'hFFFF);
  endproperty
  a_rxerr_sat: assert property (p_rxerr_sat)
    else $error("receive error counter wrapped");

  property p_ack_excluded;
    (evt_rx_good && evt_rx_is_ack && !wr) |=> $stable(s_ff.good);
  endproperty
  a_ack_excluded: assert property (p_ack_excluded)
    else $error("ack frame counted as good frame");

  property p_uatt_gate;
    (s_ff.retry == 4'h0 && !(wr && cmd_sel == SEL_RETRY)) |=>
      $stable(s_ff.uatt);
  endproperty
  a_uatt_gate: assert property (p_uatt_gate)
    else $error("unicast attempt counted with no retries");

  property p_rssi_hold;
    (!evt_rx_pkt) |=> (s_ff.rssi == $past(s_ff.rssi));
  endproperty
  a_rssi_hold: assert property (p_rssi_hold)
    else $error("signal strength changed with no packet");

  property p_preset;
    (wr && cmd_sel == SEL_TX_BYTES && evt_tx_bytes == 8'h00)
      |=> (s_ff.txb == $past(cmd_wdata));
  endproperty
  a_preset: assert property (p_preset)
    else $error("byte counter preset lost");

  property p_route;
    ##2 (repeat_broadcasts == rmc_routes(s_ff.role));
  endproperty
  a_route: assert property (p_route)
    else $error("broadcast repeat flag disagrees with role");

  property p_poll_role;
    poll_pulse |-> (s_ff.role == ROLE_IND_POLLER ||
                    s_ff.role == ROLE_NR_POLLER ||
                    $past(s_ff.role) == ROLE_IND_POLLER ||
                    $past(s_ff.role) == ROLE_NR_POLLER);
  endproperty
  a_poll_role: assert property (p_poll_role)
    else $error("poll sent outside poller role");

  // Power and role settings never leave their legal ranges
  property p_power_range;
    s_ff.power <= POWER_MAX;
  endproperty
  a_power_range: assert property (p_power_range)
    else $error("power level out of range");

  property p_role_range;
    s_ff.role <= ROLE_MAX;
  endproperty
  a_role_range: assert property (p_role_range)
    else $error("role out of range");

  // Every taken command is answered on the next edge
  property p_rsp_timing;
    cmd_valid |=> rsp_valid;
  endproperty
  a_rsp_timing: assert property (p_rsp_timing)
    else $error("command not answered");

  // A refused access returns no data
  property p_err_nodata;
    rsp_error |-> (rsp_valid && rsp_rdata == 32'h00000000);
  endproperty
  a_err_nodata: assert property (p_err_nodata)
    else $error("refused access returned data");

  // Saturated counters stay put without a host preset
  property p_good_sat;
    (s_ff.good == 16'hFFFF && !wr) |=> (s_ff.good == 16'hFFFF);
  endproperty
  a_good_sat: assert property (p_good_sat)
    else $error("good frame counter wrapped");

  property p_ackf_sat;
    (s_ff.ackf == 16'hFFFF && !wr) |=> (s_ff.ackf == 16'hFFFF);
  endproperty
  a_ackf_sat: assert property (p_ackf_sat)
    else $error("ack failure counter wrapped");

  property p_txb_sat;
    (s_ff.txb == 32'hFFFFFFFF && !wr) |=> (s_ff.txb == 32'hFFFFFFFF);
  endproperty
  a_txb_sat: assert property (p_txb_sat)
    else $error("byte counter wrapped");

  // Entering the indirect coordinator role holds unicasts
  property p_indirect_set;
    (wr && cmd_sel == SEL_ROLE && cmd_wdata == 32'h00000001)
      |=> hold_indirect;
  endproperty
  a_indirect_set: assert property (p_indirect_set)
    else $error("indirect hold not raised");

  // Timeouts reload from the link inputs after a role change
  property p_uto_reload;
    (wr && cmd_sel == SEL_ROLE && cmd_wdata <= 32'h00000006)
      |=> ##1 (s_ff.uto == $past(ucast_timeout_in));
  endproperty
  a_uto_reload: assert property (p_uto_reload)
    else $error("unicast timeout not reloaded");
endmodule : rmc_bank
`default_nettype wire

//--- testbench/rmc_host_model.sv
// Purpose: Host side of the command port, one access at a time.
// Assumes: Commands driven at the falling edge, answer one cycle later.
// Notes: Released select and data lines show the inverse of the last value.
`timescale 1ns/1ps
`default_nettype none
module rmc_host_model (
  input wire logic clk_sys,
  output logic cmd_valid,
  output logic cmd_write,
  output logic [3:0] cmd_sel,
  output logic [31:0] cmd_wdata,
  input wire logic rsp_valid,
  input wire logic rsp_error,
  input wire logic [31:0] rsp_rdata
);
  // Idle bus at time zero
  initial begin
    cmd_valid = 1'b0;
    cmd_write = 1'b0;
    cmd_sel = 4'h0;
    cmd_wdata = 32'h0;
  end
  // One read or write; a missing answer comes back unknown
  task automatic access(input logic w, input logic [3:0] s,
                        input logic [31:0] d, output logic e,
                        output logic [31:0] r);
    @(negedge clk_sys);
    cmd_valid = 1'b1;
    cmd_write = w;
    cmd_sel = s;
    cmd_wdata = d;
    @(posedge clk_sys);
    // Answer stands only in the cycle after the taking edge
    @(negedge clk_sys);
    e = rsp_valid ? rsp_error : 1'bx;
    r = rsp_valid ? rsp_rdata : 32'hX;
    cmd_valid = 1'b0;
    cmd_sel = ~s;
    cmd_wdata = ~d;
  endtask : access
endmodule : rmc_host_model
`default_nettype wire

//--- testbench/test_radio_mac_config_and_stats.sv
// Purpose: Self-checking bench for the settings and statistics bank.
// Assumes: Short tick and poll period so the poll gap is 12 cycles.
// Notes: Random values from an xorshift seeded with 70.
`timescale 1ns/1ps
`default_nettype none
module test_radio_mac_config_and_stats;
  import rmc_pkg::*;
  logic clk_sys = 1'b0;
  logic arst_n = 1'b0;
  logic cmd_valid, cmd_write, rsp_valid, rsp_error, e;
  logic [3:0] cmd_sel;
  logic [31:0] cmd_wdata, rsp_rdata, r, p, tot;
  logic [7:0] ev = 8'h0; // Event strobes, one bit each
  logic [7:0] nb = 8'h0; // Bytes sent this cycle
  logic [7:0] rssi = 8'h0;
  logic [15:0] uto = 16'h0;
  logic [1:0] region = 2'h0;
  logic [1:0] rate, pwr;
  logic [3:0] retry, npat;
  logic [5:0] nchan;
  logic ackr, sleep_ok, rep, hold, poll;
  logic [31:0] seed = 32'd70;
  int err_count = 0;
  int comparisons = 0;
  int cyc = 0;
  int n;
  always #5 clk_sys = ~clk_sys;
  rmc_host_model host_inst (.clk_sys(clk_sys), .cmd_valid(cmd_valid),
    .cmd_write(cmd_write), .cmd_sel(cmd_sel), .cmd_wdata(cmd_wdata),
    .rsp_valid(rsp_valid), .rsp_error(rsp_error), .rsp_rdata(rsp_rdata));
  rmc_bank #(.TICK_CYC(4), .POLL_PERIOD_MS(3)) rmc_bank_inst (
    .clk_sys(clk_sys), .arst_n(arst_n), .cmd_valid(cmd_valid),
    .cmd_write(cmd_write), .cmd_sel(cmd_sel), .cmd_wdata(cmd_wdata),
    .rsp_valid(rsp_valid), .rsp_error(rsp_error), .rsp_rdata(rsp_rdata),
    .evt_tx_bytes(nb), .evt_rx_pkt(ev[0]), .evt_rx_rssi(rssi),
    .evt_rx_bad(ev[1]), .evt_rx_good(ev[2]), .evt_rx_is_ack(ev[3]),
    .evt_ack_timeout(ev[4]), .evt_tx_fail(ev[5]), .evt_ucast_sent(ev[6]),
    .ucast_timeout_in(uto), .bcast_timeout_in(~uto), .region_sel(region),
    .air_data_rate(rate), .transmit_power_level(pwr),
    .unicast_retry_limit(retry), .ack_request(ackr),
    .sync_sleep_allowed(sleep_ok), .hopping_pattern_count(npat),
    .hopping_channel_count(nchan), .repeat_broadcasts(rep),
    .hold_indirect(hold), .poll_pulse(poll));
  // Xorshift source, repeatable run to run
  function logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd
  // Reset value per select code
  function logic [31:0] rstv(input int s);
    case (s)
      0, 1: return 32'h2;
      2: return 32'hA;
      10: return 32'h267;
      default: return 32'h0;
    endcase
  endfunction : rstv
  // Channel count by region and rate
  function logic [5:0] exp_chan(input int g, input int k);
    case (g)
      0: return (k == 2) ? 6'd24 : 6'd49;
      1: return (k == 2) ? 6'd35 : 6'd50;
      2: return (k == 2) ? 6'd11 : 6'd41;
      default: return 6'd12;
    endcase
  endfunction : exp_chan
  // Pattern count by region and rate
  function logic [3:0] exp_pat(input int g, input int k);
    if (g == 3 || (k == 2 && g != 1)) return 4'd8;
    return 4'd10;
  endfunction : exp_pat
  // Single comparison point
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic rd(input logic [3:0] s, input logic [31:0] exp);
    host_inst.access(1'b0, s, 32'h0, e, r);
    chk(e, 0);
    chk(r, exp);
  endtask : rd
  // Refused writes return no data either
  task automatic wr(input logic [3:0] s, input logic [31:0] d,
                    input logic bad);
    host_inst.access(1'b1, s, d, e, r);
    chk(e, bad);
    chk(r, 0);
  endtask : wr
  // One-cycle event strobe
  task automatic pulse(input logic [7:0] m);
    @(negedge clk_sys);
    ev = m;
    @(negedge clk_sys);
    ev = 8'h0;
  endtask : pulse
  task automatic finish_test();
    $display("comparisons=%0d err_count=%0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : finish_test
  // Hang guard
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      finish_test();
    end
  end
  // Main sequence
  initial begin
    repeat (16) @(posedge clk_sys);
    @(negedge clk_sys);
    arst_n = 1'b1;
    for (int i = 0; i < 16; i++) begin
      host_inst.access(1'b0, 4'(i), 32'h0, e, r);
      chk(e, i > 12);
      chk(r, (i > 12) ? 32'h0 : rstv(i));
    end
    chk({ackr, sleep_ok, hold}, 3'b110);
    $display("test reset done");
    for (int g = 0; g < 4; g++) begin
      for (int k = 0; k < 4; k++) begin
        region = 2'(g);
        uto = 16'(rnd());
        wr(SEL_AIR_RATE, k, k > 2);
        if (k < 3) begin
          chk(rate, k);
          chk(sleep_ok, k != 0);
          chk(nchan, exp_chan(g, k));
          chk(npat, exp_pat(g, k));
          rd(SEL_UCAST_TO, uto);
          rd(SEL_BCAST_TO, {16'h0000, ~uto});
        end
      end
    end
    for (int k = 0; k < 4; k++) begin
      wr(SEL_TX_POWER, k, k > 2);
      chk(pwr, (k > 2) ? 2 : k);
      rd(SEL_TX_POWER, (k > 2) ? 2 : k);
    end
    $display("test settings done");
    wr(SEL_RETRY, 32'h10, 1'b1);
    wr(SEL_RETRY, 0, 1'b0);
    chk(ackr, 0);
    pulse(8'h40);
    rd(SEL_UCAST_ATT, 0);
    wr(SEL_RETRY, 15, 1'b0);
    chk({ackr, retry}, 5'h1F);
    pulse(8'h40);
    pulse(8'h40);
    rd(SEL_UCAST_ATT, 2);
    wr(SEL_UCAST_ATT, 0, 1'b1);
    $display("test retry done");
    tot = rnd() >> 1;
    wr(SEL_TX_BYTES, tot, 1'b0);
    for (int i = 0; i < 6; i++) begin
      @(negedge clk_sys);
      nb = 8'(rnd());
      tot = tot + nb;
    end
    @(negedge clk_sys);
    nb = 8'h0;
    rd(SEL_TX_BYTES, tot);
    wr(SEL_TX_BYTES, 32'hFFFFFFF0, 1'b0);
    @(negedge clk_sys);
    nb = 8'hFF;
    @(negedge clk_sys);
    nb = 8'h0;
    rd(SEL_TX_BYTES, 32'hFFFFFFFF);
    $display("test bytes done");
    for (int j = 0; j < 3; j++) begin
      logic [3:0] s;
      logic [7:0] m;
      s = (j == 0) ? SEL_RX_ERR : (j == 1) ? SEL_GOOD : SEL_ACK_FAIL;
      m = (j == 0) ? 8'h02 : (j == 1) ? 8'h04 : 8'h10;
      wr(s, 32'h1FFFE, 1'b1);
      wr(s, 32'hFFFE, 1'b0);
      pulse(m);
      pulse(m);
      rd(s, 32'hFFFF);
      p = rnd() % 32'hFFFF;
      wr(s, p, 1'b0);
      pulse((j == 1) ? 8'h0C : 8'h00);
      pulse(m);
      rd(s, p + 1);
    end
    wr(SEL_TX_FAIL, 0, 1'b1);
    pulse(8'h20);
    rd(SEL_TX_FAIL, 1);
    rssi = 8'h28 + 8'(rnd() % 71);
    pulse(8'h01);
    rssi = ~rssi;
    rd(SEL_RSSI, {24'h000000, ~rssi});
    wr(SEL_RSSI, 0, 1'b1);
    $display("test counters done");
    for (int k = 0; k < 8; k++) begin
      wr(SEL_ROLE, k, k > 6);
      if (k < 7) begin
        chk(rep, k == 0 || k == 1 || k == 4);
        chk(hold, k == 1);
      end
      if (k == 4 || k == 6) begin
        n = 0;
        while (poll !== 1'b1 && n < 100) begin
          @(posedge clk_sys);
          #1;
          n++;
        end
        n = 0;
        do begin
          @(posedge clk_sys);
          #1;
          n++;
        end while (poll !== 1'b1 && n < 100);
        chk(n, 12);
      end
    end
    wr(SEL_ROLE, 0, 1'b0);
    n = 0;
    repeat (40) begin
      @(posedge clk_sys);
      #1;
      n = n + (poll !== 1'b0);
    end
    chk(n, 0);
    $display("test roles done");
    pulse(8'h02);
    @(negedge clk_sys);
    arst_n = 1'b0;
    repeat (2) @(negedge clk_sys);
    arst_n = 1'b1;
    rd(SEL_RX_ERR, 0);
    rd(SEL_TX_BYTES, 0);
    rd(SEL_RSSI, 0);
    $display("test second reset done");
    finish_test();
  end
endmodule : test_radio_mac_config_and_stats
`default_nettype wire
